// *** core/sdb_builder.sv ***
// sense descriptor builder: streams the selected descriptors after the header
// assumes the fixed-format record ports hold still around the start write
`timescale 1ns/1ps
module sdb_builder
   import sdb_pkg::*;
(
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CE,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // fixed-format sense record
   input wire logic REC_INFO_VALID,
   input wire logic REC_INCORRECT_LENGTH_FLAG,
   input wire logic [63:0] REC_BLOCK_ADDRESS,
   input wire logic [63:0] REC_RESIDUE,
   input wire logic [31:0] REC_CMD_INFO,
   input wire logic [23:0] REC_KEY_SPECIFIC,
   input wire logic [7:0] REC_REPLACEABLE_UNIT_CODE,
   input wire logic [15:0] REC_UNIT_ERROR_CODE,
   input wire logic [47:0] REC_PHYS_RECORD,
   // descriptor stream
   output logic [7:0] DESC_BYTE,
   output logic DESC_VALID,
   output logic DESC_LAST,
   output logic [7:0] DESC_POS,
   // header values and status
   output logic [7:0] RESP_CODE,
   output logic [7:0] SENSE_LEN,
   output logic BUSY
);
   import sdb_pkg::*;

   typedef enum logic {SDB_IDLE, SDB_EMIT} sdb_state_t;

   logic rst_meta;
   logic rst_n;
   sdb_state_t state;
   logic [6:0] sel_mask;
   logic deferred;
   logic done;
   logic [6:0] rem;
   logic [3:0] pos;
   logic [7:0] total_len;
   logic [7:0] beat_cnt;
   logic snap_valid;
   logic snap_ili;
   logic snap_blk;
   logic [63:0] snap_lba;
   logic [63:0] snap_res;
   logic [31:0] snap_cmd;
   logic [23:0] snap_key;
   logic [7:0] snap_fru;
   logic [15:0] snap_uec;
   logic [47:0] snap_phys;
   logic [2:0] cur;
   logic [6:0] rem_after;
   logic [7:0] next_total;
   logic [63:0] info_field;
   logic [7:0] gen_byte;
   logic start_go;
   logic desc_end;

   // reset release through two flops
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   assign start_go = WR && ADDR == REG_CTRL && WDATA[CTRL_START_BIT] && state == SDB_IDLE;

   // lowest pending descriptor goes next, so output order is fixed by type
   always_comb begin
      cur = 3'h0;
      for (int i = NUM_DESC - 1; i >= 0; i--) begin
         if (rem[i]) cur = 3'(i);
      end
      rem_after = rem & ~(7'h01 << cur);
   end

   // descriptor bytes that the header's length must cover
   always_comb begin
      next_total = 8'h00;
      for (int i = 0; i < NUM_DESC; i++) begin
         if (WDATA[CTRL_SEL_LSB + i]) next_total = next_total + DESC_ALEN[i] + DESC_HDR_BYTES;
      end
   end

   assign desc_end = pos == 4'(DESC_ALEN[cur] + 8'h01);

   // the residue reading only holds when a block descriptor says so
   assign info_field = (snap_ili && snap_blk) ? snap_res : snap_lba;

   sdb_desc_byte sdb_desc_byte_i (
      .kind(cur),
      .pos(pos),
      .info_valid(snap_valid),
      .incorrect_length_flag(snap_ili),
      .info_field(info_field),
      .cmd_info(snap_cmd),
      .key_specific(snap_key),
      .replaceable_unit_code(snap_fru),
      .unit_error_code(snap_uec),
      .phys_record(snap_phys),
      .data(gen_byte)
   );

   // control register
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         sel_mask <= CTRL_RESET[CTRL_SEL_LSB +: 7];
         deferred <= CTRL_RESET[CTRL_DEFER_BIT];
      end else if (CE && WR && ADDR == REG_CTRL && state == SDB_IDLE) begin
         sel_mask <= WDATA[CTRL_SEL_LSB +: 7];
         deferred <= WDATA[CTRL_DEFER_BIT];
      end
   end

   // record snapshot; the address is passed through as given, even on reassign
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         snap_valid <= 1'b0;
         snap_ili <= 1'b0;
         snap_blk <= 1'b0;
         snap_lba <= 64'h0;
         snap_res <= 64'h0;
         snap_cmd <= 32'h0;
         snap_key <= 24'h0;
         snap_fru <= 8'h00;
         snap_uec <= 16'h0000;
         snap_phys <= 48'h0;
      end else if (CE && start_go) begin
         snap_valid <= REC_INFO_VALID;
         snap_ili <= REC_INCORRECT_LENGTH_FLAG;
         snap_blk <= WDATA[CTRL_SEL_LSB + IDX_BLOCK];
         snap_lba <= REC_BLOCK_ADDRESS;
         snap_res <= REC_RESIDUE;
         snap_cmd <= REC_CMD_INFO;
         snap_key <= REC_KEY_SPECIFIC;
         snap_fru <= REC_REPLACEABLE_UNIT_CODE;
         snap_uec <= REC_UNIT_ERROR_CODE;
         snap_phys <= REC_PHYS_RECORD;
      end
   end

   // sequencer
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state <= SDB_IDLE;
         rem <= 7'h00;
         pos <= 4'h0;
      end else if (CE) begin
         unique case (state)
            SDB_IDLE: begin
               if (start_go && WDATA[CTRL_SEL_LSB +: 7] != 7'h00) begin
                  state <= SDB_EMIT;
                  rem <= WDATA[CTRL_SEL_LSB +: 7];
                  pos <= 4'h0;
               end
            end
            SDB_EMIT: begin
               if (desc_end) begin
                  rem <= rem_after;
                  pos <= 4'h0;
                  if (rem_after == 7'h00) state <= SDB_IDLE;
               end else begin
                  pos <= pos + 4'h1;
               end
            end
         endcase
      end
   end

   // stream outputs
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         DESC_BYTE <= 8'h00;
         DESC_VALID <= 1'b0;
         DESC_LAST <= 1'b0;
         DESC_POS <= 8'h00;
      end else if (CE) begin
         DESC_VALID <= state == SDB_EMIT;
         DESC_LAST <= state == SDB_EMIT && desc_end && rem_after == 7'h00;
         DESC_BYTE <= state == SDB_EMIT ? gen_byte : 8'h00;
         if (start_go) DESC_POS <= SENSE_HDR_BYTES;
         else if (DESC_VALID) DESC_POS <= DESC_POS + 8'h01;
      end
   end

   // header values and status
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         RESP_CODE <= RESP_CURRENT;
         SENSE_LEN <= 8'h00;
         total_len <= 8'h00;
         done <= 1'b0;
         BUSY <= 1'b0;
      end else if (CE) begin
         BUSY <= start_go || (state == SDB_EMIT && !(desc_end && rem_after == 7'h00));
         if (start_go) begin
            RESP_CODE <= WDATA[CTRL_DEFER_BIT] ? RESP_DEFERRED : RESP_CURRENT;
            SENSE_LEN <= next_total;
            total_len <= next_total;
         end
         // finish is only reachable while busy, so it never meets a start
         if (state == SDB_EMIT && desc_end && rem_after == 7'h00) done <= 1'b1;
         else if (start_go) done <= 1'b0;
      end
   end

   // register reads, data in the following cycle only
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 32'h0;
      end else if (CE) begin
         RDATA <= 32'h0;
         if (RD) begin
            unique case (ADDR)
               REG_CTRL: RDATA <= 32'(sel_mask) | (32'(deferred) << CTRL_DEFER_BIT);
               REG_STATUS: RDATA <= (32'(BUSY) << STAT_BUSY_BIT) | (32'(done) << STAT_DONE_BIT)
                                    | (32'(total_len) << STAT_LEN_LSB);
               default: RDATA <= 32'h0;
            endcase
         end
      end
   end

   // helper: beats since the start, for the length check
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) beat_cnt <= 8'h00;
      else if (CE && start_go) beat_cnt <= 8'h00;
      else if (CE && DESC_VALID) beat_cnt <= beat_cnt + 8'h01;
   end

   property p_type_code;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && pos == 4'h0 |=> DESC_BYTE == DESC_TYPE[$past(cur)];
   endproperty
   a_type_code: assert property (p_type_code) else $error("wrong descriptor type code");

   property p_add_len;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && pos == 4'h1 |=> DESC_BYTE == DESC_ALEN[$past(cur)];
   endproperty
   a_add_len: assert property (p_add_len) else $error("wrong additional length");

   property p_info_valid;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && cur == IDX_INFO && pos == 4'h2 |=> DESC_BYTE == {snap_valid, 7'h00};
   endproperty
   a_info_valid: assert property (p_info_valid) else $error("information valid bit wrong");

   property p_info_select;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && cur == IDX_INFO && pos == 4'h4
      |=> DESC_BYTE == ((snap_ili && snap_blk) ? snap_res[63:56] : snap_lba[63:56]);
   endproperty
   a_info_select: assert property (p_info_select) else $error("information field source wrong");

   property p_ili_bit;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && cur == IDX_BLOCK && pos == 4'h3 |=> DESC_BYTE == {2'b00, snap_ili, 5'h00};
   endproperty
   a_ili_bit: assert property (p_ili_bit) else $error("block descriptor flag byte wrong");

   property p_reserved;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && cur == IDX_CMD && pos == 4'h2 |=> DESC_BYTE == 8'h00 ##1 DESC_BYTE == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bytes not zero");

   property p_uec;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && cur == IDX_UEC && pos == 4'h2 && $stable(CE)
      |=> DESC_BYTE == snap_uec[15:8] ##1 DESC_BYTE == snap_uec[7:0] || !CE;
   endproperty
   a_uec: assert property (p_uec) else $error("unit error code bytes wrong");

   property p_fru;
      @(posedge CLOCK) disable iff (!rst_n)
      CE && state == SDB_EMIT && cur == IDX_FRU && pos == 4'h3 |=> DESC_BYTE == snap_fru;
   endproperty
   a_fru: assert property (p_fru) else $error("replaceable unit code wrong");

   property p_last_len;
      @(posedge CLOCK) disable iff (!rst_n)
      DESC_LAST |-> DESC_VALID && beat_cnt + 8'h01 == total_len;
   endproperty
   a_last_len: assert property (p_last_len) else $error("last byte count disagrees with length");

   property p_start_pos;
      @(posedge CLOCK) disable iff (!rst_n)
      $rose(DESC_VALID) |-> DESC_POS == SENSE_HDR_BYTES;
   endproperty
   a_start_pos: assert property (p_start_pos) else $error("first descriptor not at byte 8");
endmodule // sdb_builder

// *** core/sdb_desc_byte.sv ***
// byte generator: one descriptor byte from descriptor index and byte position
// assumes the record fields are held stable by the caller while emitting
`timescale 1ns/1ps
module sdb_desc_byte
   import sdb_pkg::*;
(
   // selection
   input wire logic [2:0] kind,
   input wire logic [3:0] pos,
   // record fields
   input wire logic info_valid,
   input wire logic incorrect_length_flag,
   input wire logic [63:0] info_field,
   input wire logic [31:0] cmd_info,
   input wire logic [23:0] key_specific,
   input wire logic [7:0] replaceable_unit_code,
   input wire logic [15:0] unit_error_code,
   input wire logic [47:0] phys_record,
   // result
   output logic [7:0] data
);
   logic [63:0] cmd_field;
   assign cmd_field = {32'h0000_0000, cmd_info};

   always_comb begin
      data = 8'h00;
      if (pos == 4'h0) begin
         data = DESC_TYPE[kind];
      end else if (pos == 4'h1) begin
         data = DESC_ALEN[kind];
      end else begin
         unique case (kind)
            IDX_INFO: begin
               if (pos == 4'h2) data = {info_valid, 7'h00};
               else if (pos >= 4'h4) data = info_field[8*(11-pos) +: 8];
            end
            IDX_CMD: begin
               if (pos >= 4'h4) data = cmd_field[8*(11-pos) +: 8];
            end
            IDX_KEY: begin
               if (pos >= 4'h4 && pos <= 4'h6) data = key_specific[8*(6-pos) +: 8];
            end
            IDX_FRU: begin
               if (pos == 4'h3) data = replaceable_unit_code;
            end
            IDX_BLOCK: begin
               if (pos == 4'h3) data = 8'(incorrect_length_flag) << ILI_BIT;
            end
            IDX_UEC: data = unit_error_code[8*(3-pos) +: 8];
            IDX_PHYS: data = phys_record[8*(7-pos) +: 8];
            default: data = 8'h00;
         endcase
      end
   end
endmodule // sdb_desc_byte

// *** inc/sdb_pkg.sv ***
// constants for the sense descriptor builder: type codes, lengths, register map
// assumes one system clock; the fixed-format sense record arrives on plain ports
// How it works
// - information descriptor: type 00h, eight-byte information field in bytes 4..11
// - information descriptor additional length is 0Ah
// - information byte 2 bit 7 tells whether the information field is valid
// - incorrect length clear or no block descriptor: field holds the block address
// - incorrect length set with a block descriptor: field holds the byte residue, two's complement
// - on reassign-blocks the reported address may differ from the command's
// - command-specific descriptor: type 01h, length 0Ah, bytes 2-3 zero
// - command-specific bytes copy the fixed-record command-specific field
// - key-specific descriptor: type 02h, length 06h, bytes 2, 3, 7 zero
// - key-specific bytes 4..6 copy fixed-record bytes 15..17, valid flag included
// - replaceable-unit descriptor: type 03h, length 02h, code in byte 3
// - replaceable-unit byte copies the fixed-record replaceable-unit code
// - block descriptor: type 05h, length 02h, incorrect length at byte 3 bit 5
// - the incorrect length flag selects address or residue in the information field
// - unit error descriptor: type 80h, length 02h, code in bytes 2..3
// - unit error code copies the fixed-record vendor error information
// - physical record descriptor: type 81h, length 06h, record in bytes 2..7
// - physical record bytes copy the fixed-record physical error record
// - every reserved bit and byte is zero
// - byte 1 counts the descriptor bytes that follow it
// - descriptors start at sense byte 8 after a 72h or 73h header
package sdb_pkg;
   localparam int NUM_DESC = 7;
   // descriptor indices, also bit positions of the select mask
   localparam logic [2:0] IDX_INFO = 3'h0;
   localparam logic [2:0] IDX_CMD = 3'h1;
   localparam logic [2:0] IDX_KEY = 3'h2;
   localparam logic [2:0] IDX_FRU = 3'h3;
   localparam logic [2:0] IDX_BLOCK = 3'h4;
   localparam logic [2:0] IDX_UEC = 3'h5;
   localparam logic [2:0] IDX_PHYS = 3'h6;
   localparam logic [6:0][7:0] DESC_TYPE = {8'h81, 8'h80, 8'h05, 8'h03, 8'h02, 8'h01, 8'h00};
   localparam logic [6:0][7:0] DESC_ALEN = {8'h06, 8'h02, 8'h02, 8'h02, 8'h06, 8'h0A, 8'h0A};
   localparam logic [7:0] DESC_HDR_BYTES = 8'h02;
   localparam int VALID_BIT = 7;
   localparam int ILI_BIT = 5;
   localparam logic [7:0] RESP_CURRENT = 8'h72;
   localparam logic [7:0] RESP_DEFERRED = 8'h73;
   localparam logic [7:0] SENSE_HDR_BYTES = 8'h08;
   // register map (word index on the plain port)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_DEFER_BIT = 8;
   localparam int CTRL_START_BIT = 31;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_LEN_LSB = 8;
endpackage

// *** testbench/sdb_builder_bench.sv ***
// self-checking bench for the sense descriptor builder: table of masks, then hand-written cases
// assumes the host model is compiled first; record values stay fixed except the two flags
`timescale 1ns/1ps
module sdb_builder_bench;
   import sdb_pkg::*;
   typedef struct packed {logic [6:0] mask; logic incorrect_length_flag; logic iv;} sdb_row_t;
   localparam logic [63:0] ADDR_V = 64'h0123_4567_89AB_CDEF;
   localparam logic [63:0] RES_V = 64'hFFFF_FFFF_FFFF_FFF0;
   logic clock = 1'h0, rstn = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0, iv = 1'h0, incorrect_length_flag = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [7:0] dbyte, dpos, resp, slen;
   logic dvalid, dlast, busy;
   logic [31:0] cmd_v = 32'hA1B2_C3D4;
   logic [23:0] key_v = 24'h8C_1234;
   logic [7:0] fru_v = 8'h5A;
   logic [15:0] uec_v = 16'h3C7E;
   logic [47:0] phys_v = 48'h0102_0304_0506;
   logic [7:0] exp_q[$];
   int errors = 0, checks_done = 0;
   sdb_row_t rows[9] = '{'{7'h01, 1'h0, 1'h1}, '{7'h02, 1'h0, 1'h1}, '{7'h04, 1'h0, 1'h1},
      '{7'h08, 1'h0, 1'h1}, '{7'h10, 1'h1, 1'h1}, '{7'h20, 1'h0, 1'h1}, '{7'h40, 1'h0, 1'h1},
      '{7'h7F, 1'h0, 1'h0}, '{7'h01, 1'h1, 1'h1}};

   sdb_builder sdb_builder_i (.CLOCK(clock), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .REC_INFO_VALID(iv), .REC_INCORRECT_LENGTH_FLAG(incorrect_length_flag),
      .REC_BLOCK_ADDRESS(ADDR_V), .REC_RESIDUE(RES_V), .REC_CMD_INFO(cmd_v), .REC_KEY_SPECIFIC(key_v),
      .REC_REPLACEABLE_UNIT_CODE(fru_v), .REC_UNIT_ERROR_CODE(uec_v), .REC_PHYS_RECORD(phys_v),
      .DESC_BYTE(dbyte), .DESC_VALID(dvalid), .DESC_LAST(dlast), .DESC_POS(dpos), .RESP_CODE(resp),
      .SENSE_LEN(slen), .BUSY(busy));
   sdb_host_model sdb_host_model_i (.clk(clock), .rst_n(rstn), .valid(dvalid), .last(dlast), .dbyte(dbyte),
      .pos(dpos));

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      errors += sdb_host_model_i.errs;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // entered just after a rising edge; strobes last exactly one cycle
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clock);
      wr <= 1'h0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'h1;
      @(posedge clock);
      rd <= 1'h0;
      // read data stand in the following cycle; take them at the edge that closes it
      @(posedge clock);
      d = rdata;
   endtask

   task automatic push(input logic [63:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[8*i +: 8]);
   endtask

   task automatic build(input sdb_row_t r);
      exp_q = {};
      if (r.mask[0]) push({16'h000A, r.iv, 15'h0}, 4);
      if (r.mask[0]) push((r.incorrect_length_flag && r.mask[4]) ? RES_V : ADDR_V, 8);
      if (r.mask[1]) push({32'h010A_0000, 32'h0}, 8);
      if (r.mask[1]) push(cmd_v, 4);
      if (r.mask[2]) push({32'h0206_0000, key_v, 8'h00}, 8);
      if (r.mask[3]) push({24'h0302_00, fru_v}, 4);
      if (r.mask[4]) push({24'h0502_00, 2'h0, r.incorrect_length_flag, 5'h0}, 4);
      if (r.mask[5]) push({16'h8002, uec_v}, 4);
      if (r.mask[6]) push({16'h8106, phys_v}, 8);
   endtask

   task automatic run(input sdb_row_t r, input logic defer, input logic [6:0] late);
      int f0;
      logic [31:0] st;
      f0 = sdb_host_model_i.frames;
      iv <= r.iv;
      incorrect_length_flag <= r.incorrect_length_flag;
      build(r);
      wr_reg(REG_CTRL, {1'h1, 22'h0, defer, 1'h0, r.mask});
      if (late != 7'h0) begin
         @(posedge clock);
         wr_reg(REG_CTRL, {1'h1, 24'h0, late});
      end
      for (int i = 0; i < 100 && sdb_host_model_i.frames == f0; i++) @(posedge clock);
      chk(sdb_host_model_i.frames - f0, 1);
      chk(sdb_host_model_i.got.size(), exp_q.size());
      foreach (exp_q[i]) chk(sdb_host_model_i.got[i], exp_q[i]);
      chk(slen, exp_q.size());
      chk(resp, defer ? RESP_DEFERRED : RESP_CURRENT);
      repeat (2) @(posedge clock);
      rd_reg(REG_STATUS, st);
      chk(st[15:0], {8'(exp_q.size()), 8'h02});
      chk(busy, 1'h0);
      rd_reg(REG_CTRL, st);
      chk(st, {23'h0, defer, 1'h0, r.mask});
   endtask

   initial begin
      logic [31:0] st;
      repeat (12) @(posedge clock);
      chk(resp, RESP_CURRENT);
      chk({dvalid, busy, slen}, 10'h0);
      rstn <= 1'h1;
      repeat (3) @(posedge clock);
      $display("test reset done");
      foreach (rows[i]) begin
         run(rows[i], 1'h0, 7'h0);
         $display("test row %0d done", i);
      end
      // every descriptor, residue in the information field, deferred header
      run(sdb_row_t'{7'h7F, 1'h1, 1'h1}, 1'h1, 7'h0);
      $display("test deferred done");
      // a second start while the first stream runs must not change it
      run(sdb_row_t'{7'h01, 1'h0, 1'h1}, 1'h0, 7'h40);
      $display("test start while busy done");
      @(posedge clock);
      wr_reg(4'h9, 32'hFFFF_FFFF);
      rd_reg(4'h9, st);
      chk(st, 32'h0);
      $display("test unmapped done");
      end_sim;
   end

   // the whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      errors++;
      end_sim;
   end
endmodule // sdb_builder_bench

// *** testbench/sdb_host_model.sv ***
// host side of the descriptor stream: gathers each frame of bytes and checks offsets and gap-free delivery
// assumes one clock and that the builder flags the last byte of every frame
`timescale 1ns/1ps
module sdb_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // descriptor stream
   input wire logic valid,
   input wire logic last,
   input wire logic [7:0] dbyte,
   input wire logic [7:0] pos
);
   logic [7:0] got[$];
   logic in_frame = 1'h0;
   int frames = 0;
   int errs = 0;
   // the host gathers bytes and checks their offsets, never their content; an internal-failure address is never read as a media spot
   always @(posedge clk) begin
      if (!rst_n) begin
         in_frame = 1'h0;
      end else if (valid) begin
         if (!in_frame) got = {};
         if (pos !== 8'h08 + got.size()) errs++;
         got.push_back(dbyte);
         in_frame = !last;
         if (last) frames++;
      end else if (in_frame) begin
         errs++;
      end
   end
endmodule // sdb_host_model
